// File: iomad_top.sv
// converter control, result latch and io decode for a processor io space
`timescale 1ns/1ps
module iomad_top
  import iomad_pkg::*;
#(
  parameter int CONV_CYCLES = IOMAD_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic softwareFlagOutput,
  input wire logic [IOMAD_ADDR_W-1:0] address,
  input wire logic ioSpaceStrobe_n,
  input wire logic busStrobe_n,
  input wire logic readWrite,
  input wire logic [IOMAD_DATA_W-1:0] analogSample,
  output logic branchTestInput,
  output logic sampleHold,
  output logic [IOMAD_DATA_W-1:0] heldSample,
  output logic ready_n,
  output logic [7:0] deviceSelect_n,
  output logic readResultEnable_n,
  output logic latchOutputControl_n,
  output logic [IOMAD_BUS_W-1:0] dataOut,
  output logic dataOutEn,
  output logic resultValid,
  input wire logic resultReady,
  output logic [IOMAD_DATA_W-1:0] resultData
);
  // two-stage synchronisers for pins
  logic startMeta_r, startSync_r, startPrev_r;
  logic [IOMAD_ADDR_W-1:0] addrMeta_r, addrSync_r;
  logic isMeta_r, isSync_r, strbMeta_r, strbSync_r, rwMeta_r, rwSync_r;
  logic [IOMAD_DATA_W-1:0] anaMeta_r, anaSync_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      startMeta_r <= 1'b0;
      startSync_r <= 1'b0;
      startPrev_r <= 1'b0;
      addrMeta_r <= '0;
      addrSync_r <= '0;
      isMeta_r <= 1'b1;
      isSync_r <= 1'b1;
      strbMeta_r <= 1'b1;
      strbSync_r <= 1'b1;
      rwMeta_r <= 1'b1;
      rwSync_r <= 1'b1;
      anaMeta_r <= '0;
      anaSync_r <= '0;
    end
    else
    begin
      startMeta_r <= softwareFlagOutput;
      startSync_r <= startMeta_r;
      startPrev_r <= startSync_r;
      addrMeta_r <= address;
      addrSync_r <= addrMeta_r;
      isMeta_r <= ioSpaceStrobe_n;
      isSync_r <= isMeta_r;
      strbMeta_r <= busStrobe_n;
      strbSync_r <= strbMeta_r;
      rwMeta_r <= readWrite;
      rwSync_r <= rwMeta_r;
      anaMeta_r <= analogSample;
      anaSync_r <= anaMeta_r;
    end
  end

  // conversion sequencer
  iomad_state_t state_r, state_nxt;
  logic [IOMAD_CNT_W-1:0] convCnt_r, convCnt_nxt;
  logic busy_r, busyPrev_r;
  logic [IOMAD_DATA_W-1:0] sar_r, sar_nxt;
  logic [IOMAD_DATA_W-1:0] heldSample_r;

  // software flag drives start; the sequencer reacts to its rising edge
  wire startRise = startSync_r && !startPrev_r;
  wire convEnd = (convCnt_r == IOMAD_CNT_W'(CONV_CYCLES - 1));
  localparam int LastBitCycle = CONV_CYCLES - IOMAD_LSB_LEAD_CYCLES - 1;
  // conversions shorter than the msb time leave the msb and upper bits undecided
  localparam int BitStep = (LastBitCycle - IOMAD_MSB_CYCLES) / (IOMAD_DATA_W - 1);

  // bit k (msb first) decided at msb time plus k steps
  logic [IOMAD_DATA_W-1:0] bitDecide;
  // converter output is the complemented twos-complement code of the held sample
  wire [IOMAD_DATA_W-1:0] convCode = ~heldSample_r;
  always_comb
  begin
    bitDecide = '0;
    for (int k = 0; k < IOMAD_DATA_W; k++)
      if (convCnt_r == IOMAD_CNT_W'(IOMAD_MSB_CYCLES + k * BitStep))
        bitDecide[IOMAD_DATA_W-1-k] = 1'b1;
  end

  always_comb
  begin
    state_nxt = state_r;
    convCnt_nxt = convCnt_r;
    sar_nxt = sar_r | (bitDecide & convCode);
    case (state_r)
      IOMAD_IDLE:
      begin
        if (startRise)
        begin
          state_nxt = IOMAD_CONV;
          convCnt_nxt = '0;
          sar_nxt = '0;
        end
      end
      IOMAD_CONV:
      begin
        convCnt_nxt = convCnt_r + IOMAD_CNT_W'(1);
        if (convEnd)
          state_nxt = IOMAD_DONE;
      end
      IOMAD_DONE:
        state_nxt = IOMAD_IDLE;
      default:
        state_nxt = IOMAD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= IOMAD_IDLE;
      convCnt_r <= '0;
      sar_r <= '0;
      busy_r <= 1'b0;
      busyPrev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      convCnt_r <= convCnt_nxt;
      sar_r <= sar_nxt;
      busy_r <= (state_nxt == IOMAD_CONV);
      busyPrev_r <= busy_r;
    end
  end

  // sample-and-hold: tracks inverted input while busy low, freezes while high
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      heldSample_r <= '0;
    else if (!busy_r)
      heldSample_r <= ~anaSync_r + IOMAD_DATA_W'(1);
  end

  // busy length, compared against the conversion time at every busy fall
  logic [IOMAD_CNT_W-1:0] busyLen_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      busyLen_r <= '0;
    else if (busy_r)
      busyLen_r <= busyLen_r + IOMAD_CNT_W'(1);
    else
      busyLen_r <= '0;
  end

  // result latch on busy falling edge, inverting every bit
  wire busyFall = busyPrev_r && !busy_r;
  logic [IOMAD_DATA_W-1:0] result_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result_r <= '0;
    else if (busyFall)
      result_r <= ~sar_r;
  end

  // io decode: ready decode kept apart from the strobe-gated select decode
  wire readyDec_n = isSync_r | addrSync_r[IOMAD_WAIT_BIT];
  logic [7:0] selDec_n;
  always_comb
  begin
    selDec_n = 8'hFF;
    if (!strbSync_r && !isSync_r && !addrSync_r[IOMAD_WAIT_BIT])
      selDec_n[addrSync_r[2:0]] = 1'b0;
  end
  wire decoderSelectZero_n = selDec_n[IOMAD_RESULT_PORT];
  wire readEn_n = decoderSelectZero_n | ~rwSync_r;

  logic branch_r, sh_r, ready_r, rdEn_r, oc_r, oe_r;
  logic [7:0] sel_r;
  logic [IOMAD_BUS_W-1:0] dout_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      branch_r <= 1'b0;
      sh_r <= 1'b0;
      ready_r <= 1'b1;
      sel_r <= 8'hFF;
      rdEn_r <= 1'b1;
      oc_r <= 1'b1;
      oe_r <= 1'b0;
      dout_r <= '0;
    end
    else
    begin
      branch_r <= busy_r;
      sh_r <= busy_r;
      ready_r <= readyDec_n;
      sel_r <= selDec_n;
      rdEn_r <= readEn_n;
      oc_r <= readEn_n;
      oe_r <= !readEn_n;
      dout_r <= readEn_n ? '0 : {{(IOMAD_BUS_W-IOMAD_DATA_W){result_r[IOMAD_DATA_W-1]}}, result_r};
    end
  end

  assign branchTestInput = branch_r;
  assign sampleHold = sh_r;
  assign heldSample = heldSample_r;
  assign ready_n = ready_r;
  assign deviceSelect_n = sel_r;
  assign readResultEnable_n = rdEn_r;
  assign latchOutputControl_n = oc_r;
  assign dataOut = dout_r;
  assign dataOutEn = oe_r;

  // each completed result is also offered to the two-entry stream buffer, and is dropped when the buffer is full
  iomad_skid_buffer #(.WIDTH(IOMAD_DATA_W)) resultBuf (
    .clk(clk),
    .resetn(resetn),
    .inValid(busyFall),
    .inReady(),
    .inData(~sar_r),
    .outValid(resultValid),
    .outReady(resultReady),
    .outData(resultData)
  );

  // conversion checks
  convLength_a: assert property (@(posedge clk) disable iff (!resetn)
    busyFall |-> (busyLen_r == IOMAD_CNT_W'(CONV_CYCLES)))
    else $error("busy length differs from conversion time");
  msbNotEarly_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == IOMAD_CONV && convCnt_r <= IOMAD_CNT_W'(IOMAD_MSB_CYCLES)) |-> (sar_r == '0))
    else $error("bit decided before msb time");
  lsbSettled_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == IOMAD_CONV && convCnt_r == IOMAD_CNT_W'(CONV_CYCLES - IOMAD_LSB_LEAD_CYCLES)) |-> (sar_r == convCode))
    else $error("code not settled before busy fall");
  holdRelease_a: assert property (@(posedge clk) disable iff (!resetn)
    busyFall |=> !sampleHold)
    else $error("hold kept after busy fall");
  trackInput_a: assert property (@(posedge clk) disable iff (!resetn)
    !busy_r |=> (heldSample_r == -$past(anaSync_r)))
    else $error("held sample not tracking inverted input");
  busyFromStart_a: assert property (@(posedge clk) disable iff (!resetn)
    (startRise && state_r == IOMAD_IDLE) |=> busy_r)
    else $error("no busy after start edge");
  holdFollowsBusy_a: assert property (@(posedge clk) disable iff (!resetn)
    busy_r |=> sampleHold)
    else $error("hold not set while busy");
  holdFreeze_a: assert property (@(posedge clk) disable iff (!resetn)
    (busy_r && $past(busy_r)) |-> $stable(heldSample_r))
    else $error("held sample moved during hold");
  latchInvert_a: assert property (@(posedge clk) disable iff (!resetn)
    busyFall |=> result_r == ~$past(sar_r))
    else $error("result not inverted capture");

  // bus-side checks
  readyDecode_a: assert property (@(posedge clk) disable iff (!resetn)
    (!isSync_r && !addrSync_r[IOMAD_WAIT_BIT]) |=> !ready_n)
    else $error("ready missing for low port");
  writeNoDrive_a: assert property (@(posedge clk) disable iff (!resetn)
    !rwSync_r |=> !dataOutEn)
    else $error("bus driven on write");
  strobeRelease_a: assert property (@(posedge clk) disable iff (!resetn)
    strbSync_r |=> (readResultEnable_n && latchOutputControl_n && !dataOutEn))
    else $error("bus held after strobe high");
  selectIdle_a: assert property (@(posedge clk) disable iff (!resetn)
    strbSync_r |=> (deviceSelect_n == 8'hFF))
    else $error("select active without strobe");
  resultOnBus_a: assert property (@(posedge clk) disable iff (!resetn)
    !readEn_n |=> (dataOut[IOMAD_DATA_W-1:0] == $past(result_r)))
    else $error("bus shows wrong result");
endmodule

// File: iomad_pkg.sv
// package with timing and decode constants for the io-mapped converter interface
package iomad_pkg;
  localparam int IOMAD_CLK_PERIOD_NS = 10;
  localparam int IOMAD_CONV_TIME_NS = 10000;
  localparam int IOMAD_MSB_TIME_NS = 820;
  localparam int IOMAD_LSB_LEAD_NS = 40;
  localparam int IOMAD_CONV_CYCLES = IOMAD_CONV_TIME_NS / IOMAD_CLK_PERIOD_NS;
  localparam int IOMAD_MSB_CYCLES = (IOMAD_MSB_TIME_NS + IOMAD_CLK_PERIOD_NS - 1) / IOMAD_CLK_PERIOD_NS;
  localparam int IOMAD_LSB_LEAD_CYCLES = (IOMAD_LSB_LEAD_NS + IOMAD_CLK_PERIOD_NS - 1) / IOMAD_CLK_PERIOD_NS;
  localparam int IOMAD_DATA_W = 12;
  localparam int IOMAD_BUS_W = 16;
  localparam int IOMAD_ADDR_W = 4;
  localparam int IOMAD_WAIT_BIT = 3;
  localparam logic [2:0] IOMAD_RESULT_PORT = 3'h0;
  localparam int IOMAD_CNT_W = 14;
  typedef enum logic [1:0] {
    IOMAD_IDLE = 2'b00,
    IOMAD_CONV = 2'b01,
    IOMAD_DONE = 2'b10
  } iomad_state_t;
endpackage

// File: iomad_skid_buffer.sv
// two-entry valid/ready buffer for converter results
`timescale 1ns/1ps
module iomad_skid_buffer #(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // head word sits in the output register so valid and data leave straight from flops
  logic [WIDTH-1:0] head_r;
  logic headValid_r;
  logic [WIDTH-1:0] spare_r;
  logic spareValid_r;
  wire push = inValid && inReady;
  wire pop = headValid_r && outReady;
  wire headFree = pop || !headValid_r;

  assign inReady = !spareValid_r;
  assign outValid = headValid_r;
  assign outData = head_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      head_r <= '0;
      headValid_r <= 1'b0;
      spare_r <= '0;
      spareValid_r <= 1'b0;
    end
    else if (headFree)
    begin
      headValid_r <= spareValid_r || push;
      head_r <= spareValid_r ? spare_r : inData;
      spareValid_r <= 1'b0;
    end
    else if (push)
    begin
      spare_r <= inData;
      spareValid_r <= 1'b1;
    end
  end

  fullNoPush_a: assert property (@(posedge clk) disable iff (!resetn)
    spareValid_r |-> (headValid_r && !inReady))
    else $error("buffer full but ready high");
  stallHold_a: assert property (@(posedge clk) disable iff (!resetn)
    (outValid && !outReady) |=> (outValid && $stable(outData)))
    else $error("stalled word lost or changed");
endmodule

// File: iomad_cpu_model.sv
// processor-side model: start flag pulses and io bus cycles
`timescale 1ns/1ps
module iomad_cpu_model
  import iomad_pkg::*;
(
  input wire logic clk,
  output logic softwareFlagOutput,
  output logic [IOMAD_ADDR_W-1:0] address,
  output logic ioSpaceStrobe_n,
  output logic busStrobe_n,
  output logic readWrite
);
  initial
  begin
    softwareFlagOutput = 1'b0;
    address = 4'hF;
    ioSpaceStrobe_n = 1'b1;
    busStrobe_n = 1'b1;
    readWrite = 1'b1;
  end
  // set then clear, long enough to pass the input synchroniser
  task automatic pulseFlag();
    @(posedge clk);
    softwareFlagOutput <= 1'b1;
    repeat (2) @(posedge clk);
    softwareFlagOutput <= 1'b0;
  endtask
  // opens a cycle and waits until the registered outputs follow
  task automatic busStart(input logic [IOMAD_ADDR_W-1:0] a, input logic rd);
    @(posedge clk);
    address <= a;
    readWrite <= rd;
    ioSpaceStrobe_n <= 1'b0;
    busStrobe_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic busEnd();
    @(posedge clk);
    ioSpaceStrobe_n <= 1'b1;
    busStrobe_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// File: iomad_tb_top.sv
// self-checking bench for the io-mapped converter interface
`timescale 1ns/1ps
module iomad_tb_top
  import iomad_pkg::*;
;
  localparam int CONV = IOMAD_CONV_CYCLES;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [IOMAD_DATA_W-1:0] analogSample = 12'h000;
  logic resultReady = 1'b0;
  logic softwareFlagOutput, ioSpaceStrobe_n, busStrobe_n, readWrite;
  logic [IOMAD_ADDR_W-1:0] address;
  logic branchTestInput, sampleHold, ready_n, readResultEnable_n, latchOutputControl_n, dataOutEn, resultValid;
  logic [IOMAD_DATA_W-1:0] heldSample, resultData;
  logic [7:0] deviceSelect_n;
  logic [IOMAD_BUS_W-1:0] dataOut;
  int mismatches = 0;
  int testsRun = 0;
  always #5 clk = ~clk;
  iomad_cpu_model i_cpu (.clk(clk), .softwareFlagOutput(softwareFlagOutput), .address(address),
    .ioSpaceStrobe_n(ioSpaceStrobe_n), .busStrobe_n(busStrobe_n), .readWrite(readWrite));
  iomad_top #(.CONV_CYCLES(CONV)) i_dut (.clk(clk), .resetn(resetn), .softwareFlagOutput(softwareFlagOutput),
    .address(address), .ioSpaceStrobe_n(ioSpaceStrobe_n), .busStrobe_n(busStrobe_n), .readWrite(readWrite),
    .analogSample(analogSample), .branchTestInput(branchTestInput), .sampleHold(sampleHold),
    .heldSample(heldSample), .ready_n(ready_n), .deviceSelect_n(deviceSelect_n),
    .readResultEnable_n(readResultEnable_n), .latchOutputControl_n(latchOutputControl_n), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .resultValid(resultValid), .resultReady(resultReady), .resultData(resultData));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic testIdle();
    check("busy", branchTestInput, 0);
    check("ready", ready_n, 1);
    check("selects", deviceSelect_n, 8'hFF);
    check("readEnable", readResultEnable_n, 1);
    check("busDrive", dataOutEn, 0);
    check("valid", resultValid, 0);
  endtask
  // one conversion, a refused restart while busy, then a read of port 0
  task automatic testConversion(input logic [11:0] s, input bit pop);
    int cnt;
    logic [11:0] neg;
    logic [11:0] trk;
    neg = -s;
    trk = ~s;
    trk = -trk;
    @(posedge clk);
    analogSample <= s;
    i_cpu.pulseFlag();
    cnt = 0;
    while (branchTestInput !== 1'b1 && cnt < 10)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("holdOnStart", sampleHold, 1);
    @(posedge clk);
    analogSample <= ~s;
    i_cpu.pulseFlag();
    repeat (2) @(posedge clk);
    #1;
    check("heldFrozen", heldSample, neg);
    cnt = 6;
    while (branchTestInput === 1'b1 && cnt < 2000)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("busyCycles", 16'(cnt), 16'(CONV));
    check("holdReleased", sampleHold, 0);
    cnt = 0;
    while (resultValid !== 1'b1 && cnt < 10)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("tracking", heldSample, trk);
    check("resultValid", resultValid, 1);
    i_cpu.busStart(4'h0, 1'b1);
    #1;
    check("readData", dataOut, {{4{neg[11]}}, neg});
    check("busDrive", dataOutEn, 1);
    check("readEnable", readResultEnable_n, 0);
    check("latchControl", latchOutputControl_n, 0);
    i_cpu.busEnd();
    #1;
    check("busReleased", dataOutEn, 0);
    check("readEnableOff", readResultEnable_n, 1);
    check("noRestart", branchTestInput, 0);
    if (pop)
    begin
      check("streamData", resultData, neg);
      @(posedge clk);
      resultReady <= 1'b1;
      @(posedge clk);
      resultReady <= 1'b0;
    end
  endtask
  task automatic testDecode();
    for (int a = 0; a < 16; a++)
      for (int rd = 0; rd < 2; rd++)
      begin
        i_cpu.busStart(4'(a), rd[0]);
        #1;
        check("ready", ready_n, (a < 8) ? 16'h0 : 16'h1);
        if (a < 8)
          check("select", deviceSelect_n, 8'(~(8'h01 << a)));
        else
          check("select", deviceSelect_n, 8'hFF);
        check("readEnable", readResultEnable_n, (a == 0 && rd == 1) ? 16'h0 : 16'h1);
        check("busDrive", dataOutEn, (a == 0 && rd == 1) ? 16'h1 : 16'h0);
        i_cpu.busEnd();
        #1;
        check("idleSelects", deviceSelect_n, 8'hFF);
        check("idleDrive", dataOutEn, 0);
      end
  endtask
  // receiver stalls through three results: two kept in order, third dropped
  task automatic testBuffer();
    testConversion(12'h7FF, 1'b0);
    testConversion(12'h800, 1'b0);
    testConversion(12'h123, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      check("bufValid", resultValid, 1);
      check("bufData", resultData, (i == 0) ? 16'h801 : 16'h800);
      @(posedge clk);
      resultReady <= 1'b1;
      @(posedge clk);
      resultReady <= 1'b0;
      #1;
    end
    check("bufEmpty", resultValid, 0);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stopTest();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    testIdle();
    testConversion(12'h005, 1'b1);
    testConversion(12'hF00, 1'b1);
    testDecode();
    testBuffer();
    stopTest();
  end
endmodule
